// *** rtl/rxc_pkg.sv ***
// rxc_pkg: constants and carriers for the receive channel parameter block
// assumes a 32-bit classic wishbone register bus and a 32-bit memory port
package rxc_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_TABLE_BASE = 6'h00; // channel_table_base
    localparam logic [5:0] IDX_CONTROL = 6'h01;    // channel enable
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h02; // sticky events, ro
    localparam logic [5:0] IDX_IRQ_CLEAR = 6'h03;  // write one to clear
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h04; // event enables
    localparam logic [5:0] IDX_DESC_BASE = 6'h20;  // rx_descriptor_base
    localparam logic [5:0] IDX_MAX_LEN = 6'h22;    // max_rx_buffer_length
    localparam logic [5:0] IDX_STATE = 6'h24;      // rx_internal_state
    localparam logic [5:0] IDX_DATA_PTR = 6'h28;   // rx_data_pointer
    localparam logic [5:0] IDX_DESC_PTR = 6'h2c;   // rx_descriptor_pointer
    localparam logic [5:0] IDX_REMAIN = 6'h2e;     // rx_remaining_count
    localparam logic [5:0] IDX_PACK = 6'h30;       // rx_pack_word
    localparam logic [5:0] IDX_ZDS = 6'h34;        // zero_delete_state
    localparam logic [5:0] IDX_RSVD_A = 6'h38;     // reserved, reads zero
    localparam logic [5:0] IDX_SYNC = 6'h3c;       // transparent_sync_control
    localparam logic [5:0] IDX_RSVD_B = 6'h3e;     // reserved, reads zero

    // reset values
    localparam logic [31:0] STATE_RST = 32'h3900_0000;
    localparam logic [31:0] ZDS_RST = 32'h1800_0080;
    localparam logic [15:0] MAX_LEN_RST = 16'h0010;
    localparam logic [15:0] SYNC_RST = 16'h0000;

    // field positions
    localparam int BIG_ENDIAN_BIT = 28;  // bit three, msb-first numbering
    localparam int SYNC_EN_BIT = 15;     // hunt for pattern before storing
    localparam int CTRL_EN_BIT = 0;      // channel enable
    localparam int IRQ_CLOSED_BIT = 0;   // buffer closed event
    localparam int IRQ_OVERRUN_BIT = 1;  // byte lost event
    localparam int IRQ_W = 2;            // number of events

    // descriptor layout
    localparam logic [15:0] DESC_STRIDE = 16'h0008; // bytes per descriptor
    localparam logic [31:0] DESC_BUF_OFS = 32'h0000_0004; // buffer address
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;   // long word step
    localparam logic [1:0] LAST_LANE = 2'h3;              // fourth byte

    // channel sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_HUNT, ST_RECV, ST_WRITE
    } rxc_state_e;

    // memory request carrier
    typedef struct packed {
        logic we;
        logic [31:0] adr;
        logic [31:0] wdata;
    } rxc_mem_req_s;
endpackage : rxc_pkg

// *** rtl/rxc_channel.sv ***
// rxc_channel: one transparent receive channel with its parameter registers
// assumes bytes arrive from same-clock time slot logic as one-cycle strobes,
// and a memory port that answers each request with a one-cycle ack
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - never exceed max length, then next descriptor; held only when max length is a nonzero multiple of four
// - keep 32-bit absolute receive data pointer
// - descriptor address is table base plus pointer
// - keep 16-bit remaining count, decrement per byte
// - pack bytes, write only whole long words
// - middle bytes hold last sixteen received bits
// - sync control word governs reception start
// - endianness bit selects byte order
// - descriptor table at base offset from table; desc_base_reg is only stored, the address is table base plus pointer
module rxc_channel (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // received bytes from the time slot logic
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_byte_i,
    // memory master
    output logic mem_req_o,
    output rxc_pkg::rxc_mem_req_s mem_o,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_ack_i,
    // interrupt
    output logic irq_o
);
    rxc_pkg::rxc_state_e state_reg; // sequencer state
    rxc_pkg::rxc_state_e state_next; // its next value
    logic [31:0] table_base_reg; // common channel table base
    logic ctrl_en_reg; // channel enable
    logic [15:0] desc_base_reg; // descriptor table offset
    logic [15:0] max_len_reg; // bytes per buffer
    logic [31:0] state_word_reg; // internal state word
    logic [31:0] data_ptr_reg; // next write address
    logic [15:0] desc_ptr_reg; // current descriptor offset
    logic [15:0] remain_reg; // bytes still free
    logic [31:0] pack_reg; // packing word
    logic [1:0] lane_reg; // bytes held in pack
    logic [31:0] wword_reg; // long word awaiting write
    logic [31:0] zds_reg; // zero deletion state
    logic [15:0] sync_reg; // sync control word
    logic [rxc_pkg::IRQ_W-1:0] irq_stat_reg; // sticky events
    logic [rxc_pkg::IRQ_W-1:0] irq_en_reg; // event enables
    logic [rxc_pkg::IRQ_W-1:0] irq_set; // events this cycle
    logic ack_reg; // bus answer
    logic [31:0] rdata_reg; // bus read data
    logic [31:0] rdata_next; // read mux
    rxc_pkg::rxc_mem_req_s mem_reg; // registered memory request
    logic req_reg; // memory request strobe
    logic [5:0] idx; // register index
    logic bus_wr; // write takes effect
    logic [31:0] wmask; // byte lane mask
    logic take; // byte stored this cycle
    logic word_done; // memory ack on a data write
    logic [31:0] bd_addr; // descriptor address
    logic big_endian; // bus byte order

    assign idx = wb_adr_i[7:2];
    assign big_endian = state_word_reg[rxc_pkg::BIG_ENDIAN_BIT];
    assign bd_addr = table_base_reg + {16'h0000, desc_ptr_reg};
    assign take = ce_i && rx_valid_i && (state_reg == rxc_pkg::ST_RECV);
    assign word_done = ce_i && mem_ack_i && (state_reg == rxc_pkg::ST_WRITE);

    // byte lane mask from the select lines
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign wmask[8*g +: 8] = {8{wb_sel_i[g]}};
        end
    endgenerate

    // a write lands on the edge at which ack is seen
    assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;

    // bus answer: one cycle after the strobe, dropped the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
            rdata_reg <= rdata_next;
        end
    end

    // read mux; reserved and unmapped indices read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (idx)
            rxc_pkg::IDX_TABLE_BASE: rdata_next = table_base_reg;
            rxc_pkg::IDX_CONTROL: rdata_next[rxc_pkg::CTRL_EN_BIT] = ctrl_en_reg;
            rxc_pkg::IDX_IRQ_STATUS: rdata_next[1:0] = irq_stat_reg;
            rxc_pkg::IDX_IRQ_ENABLE: rdata_next[1:0] = irq_en_reg;
            rxc_pkg::IDX_DESC_BASE: rdata_next[15:0] = desc_base_reg;
            rxc_pkg::IDX_MAX_LEN: rdata_next[15:0] = max_len_reg;
            rxc_pkg::IDX_STATE: rdata_next = state_word_reg;
            rxc_pkg::IDX_DATA_PTR: rdata_next = data_ptr_reg;
            rxc_pkg::IDX_DESC_PTR: rdata_next[15:0] = desc_ptr_reg;
            rxc_pkg::IDX_REMAIN: rdata_next[15:0] = remain_reg;
            rxc_pkg::IDX_PACK: rdata_next = pack_reg;
            rxc_pkg::IDX_ZDS: rdata_next = zds_reg;
            rxc_pkg::IDX_SYNC: rdata_next[15:0] = sync_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // host-only configuration registers
    // length taken as written, multiple of four
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            table_base_reg <= 32'h0000_0000;
            ctrl_en_reg <= 1'b0;
            desc_base_reg <= 16'h0000;
            max_len_reg <= rxc_pkg::MAX_LEN_RST;
            state_word_reg <= rxc_pkg::STATE_RST;
            sync_reg <= rxc_pkg::SYNC_RST;
            irq_en_reg <= '0;
        end else if (ce_i && bus_wr) begin
            unique case (idx)
                rxc_pkg::IDX_TABLE_BASE: table_base_reg <=
                    (table_base_reg & ~wmask) | (wb_dat_i & wmask);
                rxc_pkg::IDX_CONTROL: if (wb_sel_i[0]) begin
                    ctrl_en_reg <= wb_dat_i[rxc_pkg::CTRL_EN_BIT];
                end
                rxc_pkg::IDX_IRQ_ENABLE: if (wb_sel_i[0]) begin
                    irq_en_reg <= wb_dat_i[1:0];
                end
                rxc_pkg::IDX_DESC_BASE: desc_base_reg <=
                    (desc_base_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                rxc_pkg::IDX_MAX_LEN: max_len_reg <=
                    (max_len_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                rxc_pkg::IDX_STATE: state_word_reg <=
                    (state_word_reg & ~wmask) | (wb_dat_i & wmask);
                rxc_pkg::IDX_SYNC: sync_reg <=
                    (sync_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                default: ;
            endcase
        end
    end

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            rxc_pkg::ST_IDLE: if (ctrl_en_reg) begin
                state_next = rxc_pkg::ST_FETCH;
            end
            rxc_pkg::ST_FETCH: if (mem_ack_i) begin
                state_next = sync_reg[rxc_pkg::SYNC_EN_BIT] ?
                    rxc_pkg::ST_HUNT : rxc_pkg::ST_RECV;
            end
            rxc_pkg::ST_HUNT: if (rx_valid_i && rx_byte_i == sync_reg[7:0]) begin
                state_next = rxc_pkg::ST_RECV;
            end
            rxc_pkg::ST_RECV: if (rx_valid_i && lane_reg == rxc_pkg::LAST_LANE) begin
                state_next = rxc_pkg::ST_WRITE;
            end
            rxc_pkg::ST_WRITE: if (mem_ack_i) begin
                state_next = (remain_reg == 16'h0000) ?
                    rxc_pkg::ST_FETCH : rxc_pkg::ST_RECV;
            end
        endcase
        if (!ctrl_en_reg && state_reg != rxc_pkg::ST_WRITE &&
            state_reg != rxc_pkg::ST_FETCH) begin
            state_next = rxc_pkg::ST_IDLE;
        end
    end

    // sequencer state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= rxc_pkg::ST_IDLE;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    // memory request, built when a fetch or write is entered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_reg <= 1'b0;
            mem_reg <= '0;
        end else if (ce_i) begin
            if (state_next == rxc_pkg::ST_FETCH && state_reg != rxc_pkg::ST_FETCH) begin
                req_reg <= 1'b1;
                mem_reg.we <= 1'b0;
                mem_reg.adr <= (state_reg == rxc_pkg::ST_WRITE) ?
                    table_base_reg + {16'h0000, desc_ptr_reg + rxc_pkg::DESC_STRIDE}
                    + rxc_pkg::DESC_BUF_OFS : bd_addr + rxc_pkg::DESC_BUF_OFS;
                mem_reg.wdata <= 32'h0000_0000;
            end else if (state_next == rxc_pkg::ST_WRITE &&
                         state_reg != rxc_pkg::ST_WRITE) begin
                req_reg <= 1'b1;
                mem_reg.we <= 1'b1;
                mem_reg.adr <= data_ptr_reg;
                mem_reg.wdata <= big_endian ? {pack_reg[31:8], rx_byte_i} :
                    {rx_byte_i, pack_reg[23:0]};
            end else if (mem_ack_i) begin
                req_reg <= 1'b0;
            end
        end
    end
    assign mem_req_o = req_reg;
    assign mem_o = mem_reg;

    // descriptor pointer: host load, advance after a full buffer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            desc_ptr_reg <= 16'h0000;
        end else if (ce_i) begin
            if (word_done && remain_reg == 16'h0000) begin
                desc_ptr_reg <= desc_ptr_reg + rxc_pkg::DESC_STRIDE;
            end else if (bus_wr && idx == rxc_pkg::IDX_DESC_PTR) begin
                desc_ptr_reg <= (desc_ptr_reg & ~wmask[15:0]) |
                    (wb_dat_i[15:0] & wmask[15:0]);
            end
        end
    end

    // data pointer and remaining count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_ptr_reg <= 32'h0000_0000;
            remain_reg <= 16'h0000;
        end else if (ce_i) begin
            if (state_reg == rxc_pkg::ST_FETCH && mem_ack_i) begin
                data_ptr_reg <= mem_rdata_i;
                remain_reg <= max_len_reg;
            end else begin
                if (word_done) begin
                    data_ptr_reg <= data_ptr_reg + rxc_pkg::WORD_BYTES;
                end
                if (take) begin
                    remain_reg <= remain_reg - 16'h0001;
                end
            end
        end
    end

    // packing word; byte placed by bus order
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pack_reg <= 32'h0000_0000;
            lane_reg <= 2'h0;
        end else if (ce_i) begin
            if (state_reg == rxc_pkg::ST_FETCH) begin
                lane_reg <= 2'h0;
            end else if (take) begin
                lane_reg <= lane_reg + 2'h1;
                if (big_endian) begin
                    pack_reg[8*(3-lane_reg) +: 8] <= rx_byte_i;
                end else begin
                    pack_reg[8*lane_reg +: 8] <= rx_byte_i;
                end
            end
        end
    end

    // zero deletion history: middle bytes slide by one octet per byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            zds_reg <= rxc_pkg::ZDS_RST;
        end else if (ce_i) begin
            if (bus_wr && idx == rxc_pkg::IDX_ZDS) begin
                zds_reg <= (zds_reg & ~wmask) | (wb_dat_i & wmask);
            end else if (rx_valid_i && state_reg != rxc_pkg::ST_IDLE) begin
                zds_reg[23:8] <= {zds_reg[15:8], rx_byte_i};
            end
        end
    end

    // events: buffer closed, byte lost during a descriptor fetch or word write
    assign irq_set[rxc_pkg::IRQ_CLOSED_BIT] = word_done && remain_reg == 16'h0000;
    assign irq_set[rxc_pkg::IRQ_OVERRUN_BIT] = ce_i && rx_valid_i &&
        (state_reg == rxc_pkg::ST_FETCH || state_reg == rxc_pkg::ST_WRITE);

    // sticky status; a new event wins over a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= '0;
        end else if (ce_i) begin
            if (bus_wr && idx == rxc_pkg::IDX_IRQ_CLEAR && wb_sel_i[0]) begin
                irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[1:0]) | irq_set;
            end else begin
                irq_stat_reg <= irq_stat_reg | irq_set;
            end
        end
    end
    assign irq_o = |(irq_stat_reg & irq_en_reg);

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // checks
    chk_buffer_move: assert property (@(posedge clk_i) disable iff (rst_i)
        word_done && remain_reg == 16'h0000 |=> state_reg == rxc_pkg::ST_FETCH)
        else $error("full buffer did not move to next descriptor");
    chk_data_ptr: assert property (@(posedge clk_i) disable iff (rst_i)
        word_done |=> data_ptr_reg == $past(data_ptr_reg) + rxc_pkg::WORD_BYTES)
        else $error("data pointer did not step by one word");
    chk_desc_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        req_reg && !mem_reg.we && ce_i && mem_ack_i |->
        mem_reg.adr == bd_addr + rxc_pkg::DESC_BUF_OFS)
        else $error("descriptor read address wrong");
    chk_count_down: assert property (@(posedge clk_i) disable iff (rst_i)
        take |=> remain_reg == $past(remain_reg) - 16'h0001)
        else $error("remaining count not decremented");
    chk_word_pack: assert property (@(posedge clk_i) disable iff (rst_i)
        take && ctrl_en_reg && lane_reg == rxc_pkg::LAST_LANE |=>
        state_reg == rxc_pkg::ST_WRITE
        && req_reg && mem_reg.we)
        else $error("fourth byte did not start a word write");
    chk_history_win: assert property (@(posedge clk_i) disable iff (rst_i)
        take && !bus_wr |=> zds_reg[15:8] == $past(rx_byte_i))
        else $error("history window did not take the byte");
    chk_sync_hunt: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && ctrl_en_reg && state_reg == rxc_pkg::ST_HUNT && rx_valid_i &&
        rx_byte_i != sync_reg[7:0] |=> state_reg == rxc_pkg::ST_HUNT)
        else $error("left hunt without pattern");
    chk_byte_order: assert property (@(posedge clk_i) disable iff (rst_i)
        take && big_endian && lane_reg == 2'h0 && !bus_wr |=>
        pack_reg[31:24] == $past(rx_byte_i))
        else $error("big-endian first byte misplaced");
    chk_open_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && state_reg == rxc_pkg::ST_FETCH && mem_ack_i |=>
        remain_reg == $past(max_len_reg) && data_ptr_reg == $past(mem_rdata_i))
        else $error("new buffer not reloaded");
endmodule : rxc_channel

`default_nettype wire

// *** verif/rxc_mem_model.sv ***
// rxc_mem_model: system memory behind the channel's memory master port
// assumes one outstanding request, held until the one-cycle ack
`timescale 1ns/1ps
`default_nettype none
module rxc_mem_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request from the channel
    input wire logic mem_req_i,
    input wire rxc_pkg::rxc_mem_req_s mem_i,
    input wire logic [3:0] delay_i,
    // answer to the channel
    output logic [31:0] rdata_o,
    output logic ack_o,
    // observation for the bench
    output logic [31:0] last_adr_o,
    output logic [31:0] last_wdata_o,
    output int n_rd_o,
    output int n_wr_o
);
    logic [3:0] wait_q; // cycles the current request has waited

    // answer after delay_i wait cycles; read data toggles when not valid
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            wait_q <= 4'h0;
            n_rd_o <= 0;
            n_wr_o <= 0;
            rdata_o <= 32'h5a5a_a5a5;
            last_adr_o <= 32'h0000_0000;
            last_wdata_o <= 32'h0000_0000;
        end else begin
            ack_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (mem_req_i && !ack_o) begin
                if (wait_q >= delay_i) begin
                    ack_o <= 1'b1;
                    wait_q <= 4'h0;
                    last_adr_o <= mem_i.adr;
                    if (mem_i.we) begin
                        n_wr_o <= n_wr_o + 1;
                        last_wdata_o <= mem_i.wdata;
                    end else begin
                        n_rd_o <= n_rd_o + 1;
                        rdata_o <= {mem_i.adr[15:0], 16'h0000};
                    end
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end
endmodule : rxc_mem_model
`default_nettype wire

// *** verif/tb_top.sv ***
// tb_top: register and byte stream scenarios for the receive channel
// assumes the memory model answers the channel's memory port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00, rx_byte = 8'h00;
    logic [31:0] dat = 32'h0000_0000, rd, wb_dat_o, rdata, m_adr, m_wd;
    logic wb_ack_o, rx_valid = 1'b0, mem_req, mem_ack, irq, ce = 1'b1;
    logic [3:0] dly = 4'h0, sel = 4'hf;
    rxc_pkg::rxc_mem_req_s mem;
    int n_rd, n_wr, num_errors = 0, n_checks = 0;
    always #50 clk_i = ~clk_i;
    rxc_channel i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid), .rx_byte_i(rx_byte),
        .mem_req_o(mem_req), .mem_o(mem), .mem_rdata_i(rdata),
        .mem_ack_i(mem_ack), .irq_o(irq));
    rxc_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_req_i(mem_req),
        .mem_i(mem), .delay_i(dly), .rdata_o(rdata), .ack_o(mem_ack),
        .last_adr_o(m_adr), .last_wdata_o(m_wd), .n_rd_o(n_rd),
        .n_wr_o(n_wr));
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // verdict
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    // one classic wishbone cycle, waits for ack
    task automatic wb(input logic w, input logic [5:0] idx,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= d;
        // no local limit: only the watchdog ends a hung wait
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask : wb
    // read a register and compare
    task automatic rchk(input logic [5:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 32'h0000_0000);
        check(rd, exp);
    endtask : rchk
    // look at the interrupt line once register updates have settled
    task automatic ichk(input logic exp);
        @(negedge clk_i);
        check(32'(irq), 32'(exp));
    endtask : ichk
    // one byte strobe
    task automatic put(input logic [7:0] b);
        @(posedge clk_i);
        rx_valid <= 1'b1;
        rx_byte <= b;
        @(posedge clk_i);
        rx_valid <= 1'b0;
    endtask : put
    // wait for the memory counters to reach given values
    task automatic mwait(input int r, input int w);
        int k;
        for (k = 0; k < 200 && !(n_rd == r && n_wr == w); k++)
            @(posedge clk_i);
        check(32'(n_rd == r && n_wr == w), 32'h0000_0001);
    endtask : mwait
    // watchdog
    initial begin
        #3000000;
        num_errors++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(rxc_pkg::IDX_STATE, 32'h3900_0000);
        rchk(rxc_pkg::IDX_ZDS, 32'h1800_0080);
        rchk(rxc_pkg::IDX_MAX_LEN, 32'h0000_0010);
        rchk(rxc_pkg::IDX_SYNC, 32'h0000_0000);
        wb(1'b1, rxc_pkg::IDX_RSVD_A, 32'hffff_ffff);
        rchk(rxc_pkg::IDX_RSVD_A, 32'h0000_0000);
        rchk(6'h05, 32'h0000_0000);
        wb(1'b1, rxc_pkg::IDX_DATA_PTR, 32'h1234_5678);
        rchk(rxc_pkg::IDX_DATA_PTR, 32'h0000_0000);
        wb(1'b1, rxc_pkg::IDX_TABLE_BASE, 32'h0000_1000);
        wb(1'b1, rxc_pkg::IDX_DESC_BASE, 32'h0000_0000);
        wb(1'b1, rxc_pkg::IDX_DESC_PTR, 32'h0000_0000);
        wb(1'b1, rxc_pkg::IDX_MAX_LEN, 32'h0000_0008);
        wb(1'b1, rxc_pkg::IDX_STATE, 32'h3900_0000);
        wb(1'b1, rxc_pkg::IDX_ZDS, 32'h1800_0080);
        wb(1'b1, rxc_pkg::IDX_IRQ_ENABLE, 32'h0000_0003);
        wb(1'b1, rxc_pkg::IDX_CONTROL, 32'h0000_0001);
        mwait(1, 0);
        check(m_adr, 32'h0000_1004);
        rchk(rxc_pkg::IDX_DATA_PTR, 32'h1004_0000);
        rchk(rxc_pkg::IDX_REMAIN, 32'h0000_0008);
        put(8'h11);
        put(8'h22);
        put(8'h33);
        rchk(rxc_pkg::IDX_REMAIN, 32'h0000_0005);
        put(8'h44);
        mwait(1, 1);
        check(m_adr, 32'h1004_0000);
        check(m_wd, 32'h1122_3344);
        rchk(rxc_pkg::IDX_DATA_PTR, 32'h1004_0004);
        rchk(rxc_pkg::IDX_ZDS, 32'h1833_4480);
        ichk(1'b0);
        put(8'h55);
        put(8'h66);
        put(8'h77);
        put(8'h88);
        mwait(2, 2);
        check(m_adr, 32'h0000_100c);
        check(m_wd, 32'h5566_7788);
        rchk(rxc_pkg::IDX_DESC_PTR, 32'h0000_0008);
        rchk(rxc_pkg::IDX_REMAIN, 32'h0000_0008);
        rchk(rxc_pkg::IDX_DATA_PTR, 32'h100c_0000);
        rchk(rxc_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
        ichk(1'b1);
        wb(1'b1, rxc_pkg::IDX_IRQ_ENABLE, 32'h0000_0000);
        ichk(1'b0);
        wb(1'b1, rxc_pkg::IDX_IRQ_ENABLE, 32'h0000_0003);
        wb(1'b1, rxc_pkg::IDX_IRQ_CLEAR, 32'h0000_0001);
        ichk(1'b0);
        rchk(rxc_pkg::IDX_IRQ_CLEAR, 32'h0000_0000);
        wb(1'b1, rxc_pkg::IDX_STATE, 32'h2000_0000);
        rchk(rxc_pkg::IDX_SYNC, 32'h0000_0000);
        dly <= 4'h8;
        put(8'haa);
        put(8'hbb);
        put(8'hcc);
        put(8'hdd);
        put(8'hee);
        mwait(2, 3);
        check(m_wd, 32'hddcc_bbaa);
        rchk(rxc_pkg::IDX_IRQ_STATUS, 32'h0000_0002);
        rchk(rxc_pkg::IDX_REMAIN, 32'h0000_0004);
        // next buffer opens in hunt; first sync write uses one lane only
        dly <= 4'h0;
        sel <= 4'h1;
        ichk(1'b1);
        wb(1'b1, rxc_pkg::IDX_SYNC, 32'h0000_ff55);
        sel <= 4'hf;
        rchk(rxc_pkg::IDX_SYNC, 32'h0000_0055);
        wb(1'b1, rxc_pkg::IDX_SYNC, 32'h0000_8055);
        put(8'h01);
        put(8'h02);
        put(8'h03);
        put(8'h04);
        mwait(3, 4);
        check(m_adr, 32'h0000_1014);
        check(m_wd, 32'h0403_0201);
        put(8'h99);
        put(8'h55);
        put(8'h66);
        // a strobe while the clock enable is low must change nothing
        ce <= 1'b0;
        put(8'h77);
        ce <= 1'b1;
        rchk(rxc_pkg::IDX_REMAIN, 32'h0000_0007);
        rchk(rxc_pkg::IDX_ZDS, 32'h1855_6680);
        rchk(rxc_pkg::IDX_PACK, 32'h0403_0266);
        close_out();
    end
endmodule : tb_top
`default_nettype wire
